/* include/pdl_defines.svh */
// Offsets, field positions, reset values and rule summary for the port data and lock block
// Function
// - Input word returns sampled pin levels in bits 15:0; writes ignored.
// - Sixteen-bit output latch, read/write, resets to zero, drives pin levels.
// - A one in set/clear bits 15:0 sets that latch bit; zero leaves it.
// - A one in set/clear bits 31:16 clears that latch bit; zero leaves it.
// - Set and clear together on one pin: set wins.
// - Set/clear register always reads as zero.
// - Any out-of-order or wrong-valued key write abandons arming.
// - After a good sequence key reads one and config stays frozen until reset.
// - Pin mask bits are writable only while the key bit is zero.
// - Pins marked in the mask get their configuration fields frozen when armed.
// - Key bit is readable anytime and changes only through the key sequence.
// - Mask bit zero leaves pin unlocked, one selects it; all clear on reset.
// - Clear-only register clears latch bits written one and reads as zero.
`ifndef PDL_DEFINES_SVH
`define PDL_DEFINES_SVH
`define PDL_OFS_INPUT    8'h10
`define PDL_OFS_LATCH    8'h14
`define PDL_OFS_SETCLR   8'h18
`define PDL_OFS_LOCK     8'h1C
`define PDL_OFS_CLRONLY  8'h28
`define PDL_PIN_W        16
`define PDL_KEY_BIT      16
`define PDL_CLR_LSB      16
`define PDL_CLR_MSB      31
`define PDL_LATCH_RST    16'h0000
`define PDL_MASK_RST     16'h0000
`define PDL_WORD_ZERO    32'h0000_0000
`endif

/* include/pdl_pkg.sv */
// Types shared by the port data and lock block
package pdl_pkg;
    typedef enum logic [1:0] {
        PDL_LK_IDLE,
        PDL_LK_FIRST,
        PDL_LK_SECOND,
        PDL_LK_ARMED
    } pdl_lock_state_t;
endpackage

/* rtl/pdl_lock_seq.sv */
// Lock key sequencer with per-pin freeze mask
`timescale 1ns/1ps
`default_nettype none
`include "pdl_defines.svh"
module pdl_lock_seq #(
    parameter int PIN_W = `PDL_PIN_W
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             wr_in,
    input  wire logic             key_wr_in,
    input  wire logic [PIN_W-1:0] mask_wr_in,
    output logic                  key_out,
    output logic [PIN_W-1:0]      mask_out,
    output logic [PIN_W-1:0]      freeze_out
);
    pdl_pkg::pdl_lock_state_t state;
    pdl_pkg::pdl_lock_state_t next_state;
    logic                     same_mask;

    // After the first key write, only a write carrying the captured mask may advance the key
    assign same_mask = (mask_wr_in == mask_out);

    // Key sequence: one, zero, one, all with the same mask
    always_comb begin
        next_state = state;
        if (wr_in) begin
            unique case (state)
                pdl_pkg::PDL_LK_IDLE:
                    next_state = key_wr_in ? pdl_pkg::PDL_LK_FIRST : pdl_pkg::PDL_LK_IDLE;
                pdl_pkg::PDL_LK_FIRST: begin
                    if (!key_wr_in && same_mask) begin
                        next_state = pdl_pkg::PDL_LK_SECOND;
                    end else begin
                        next_state = key_wr_in ? pdl_pkg::PDL_LK_FIRST : pdl_pkg::PDL_LK_IDLE;
                    end
                end
                pdl_pkg::PDL_LK_SECOND: begin
                    if (key_wr_in && same_mask) begin
                        next_state = pdl_pkg::PDL_LK_ARMED;
                    end else begin
                        next_state = key_wr_in ? pdl_pkg::PDL_LK_FIRST : pdl_pkg::PDL_LK_IDLE;
                    end
                end
                pdl_pkg::PDL_LK_ARMED:
                    next_state = pdl_pkg::PDL_LK_ARMED;
            endcase
        end
    end

    // Armed is left only by reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= pdl_pkg::PDL_LK_IDLE;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // Mask follows each write until armed
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mask_out <= `PDL_MASK_RST;
        end else if (ce_in && wr_in && state != pdl_pkg::PDL_LK_ARMED) begin
            mask_out <= mask_wr_in;
        end
    end

    assign key_out    = (state == pdl_pkg::PDL_LK_ARMED);
    assign freeze_out = key_out ? mask_out : `PDL_MASK_RST;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_second_ok;
        ce_in && wr_in && state == pdl_pkg::PDL_LK_SECOND && key_wr_in && same_mask;
    endsequence

    a_key_arms: assert property (s_second_ok |=> key_out)
        else $error("key did not arm after good third write");
    a_key_sticky: assert property (key_out |=> key_out && $stable(freeze_out))
        else $error("armed lock changed before reset");
    a_mask_frozen: assert property (key_out && wr_in |=> $stable(mask_out))
        else $error("mask changed while key active");
    a_no_stray_key: assert property (
        !key_out
        && !(ce_in && wr_in && state == pdl_pkg::PDL_LK_SECOND && key_wr_in && same_mask)
        |=> !key_out)
        else $error("key set without the full sequence");
endmodule
`default_nettype wire

/* rtl/pdl_port.sv */
// Port data, atomic set/clear and configuration lock for one 16-pin port
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pdl_defines.svh"
module pdl_port #(
    parameter int PIN_W  = `PDL_PIN_W,
    parameter int ADDR_W = 8
) (
    input  wire logic              MCLK_IN,
    input  wire logic              RESET_IN,
    input  wire logic              CLK_EN_IN,
    input  wire logic [ADDR_W-1:0] ADDR_IN,
    input  wire logic [31:0]       WDATA_IN,
    input  wire logic              WR_IN,
    input  wire logic              RD_IN,
    output logic      [31:0]       RDATA_OUT,
    input  wire logic [PIN_W-1:0]  PIN_LEVEL_IN,
    output logic      [PIN_W-1:0]  OUT_LATCH_OUT,
    output logic      [PIN_W-1:0]  PIN_FREEZE_OUT,
    output logic                   LOCK_KEY_OUT
);
    logic [PIN_W-1:0] pin_level;
    logic [PIN_W-1:0] out_latch;
    logic [PIN_W-1:0] next_out_latch;
    logic [PIN_W-1:0] set_pin_bit;
    logic [PIN_W-1:0] clear_pin_bit;
    logic [PIN_W-1:0] lock_mask;
    logic             lock_key_bit;
    logic             wr_latch;
    logic             wr_setclr;
    logic             wr_lock;
    logic             wr_clronly;
    logic [31:0]      next_rdata;

    // Address match, used for every register strobe
    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0]        ofs
    );
        hit = (addr == ADDR_W'(ofs));
    endfunction

    // Write strobes per register
    assign wr_latch   = WR_IN && hit(ADDR_IN, `PDL_OFS_LATCH);
    assign wr_setclr  = WR_IN && hit(ADDR_IN, `PDL_OFS_SETCLR);
    assign wr_lock    = WR_IN && hit(ADDR_IN, `PDL_OFS_LOCK);
    assign wr_clronly = WR_IN && hit(ADDR_IN, `PDL_OFS_CLRONLY);

    // Input word sampled every enabled cycle; writes never reach it
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            pin_level <= `PDL_LATCH_RST;
        end else if (CLK_EN_IN) begin
            pin_level <= PIN_LEVEL_IN;
        end
    end

    // Set and clear masks from the atomic registers
    always_comb begin
        set_pin_bit   = '0;
        clear_pin_bit = '0;
        if (wr_setclr) begin
            set_pin_bit   = WDATA_IN[PIN_W-1:0];
            clear_pin_bit = WDATA_IN[`PDL_CLR_MSB:`PDL_CLR_LSB];
        end else if (wr_clronly) begin
            clear_pin_bit = WDATA_IN[PIN_W-1:0];
        end
    end

    // Per-pin next latch value; set is tested before clear so it wins
    genvar g;
    generate
        for (g = 0; g < PIN_W; g++) begin : g_pin
            always_comb begin
                if (wr_latch) begin
                    next_out_latch[g] = WDATA_IN[g];
                end else if (set_pin_bit[g]) begin
                    next_out_latch[g] = 1'b1;
                end else if (clear_pin_bit[g]) begin
                    next_out_latch[g] = 1'b0;
                end else begin
                    next_out_latch[g] = out_latch[g];
                end
            end
        end
    endgenerate

    // Output latch; upper write bits are dropped
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            out_latch <= `PDL_LATCH_RST;
        end else if (CLK_EN_IN) begin
            out_latch <= next_out_latch;
        end
    end

    assign OUT_LATCH_OUT = out_latch;

    // Lock key sequencer; the plain port carries whole words only
    pdl_lock_seq #(
        .PIN_W (PIN_W)
    ) i_pdl_lock_seq (
        .clk_in     (MCLK_IN),
        .rst_in     (RESET_IN),
        .ce_in      (CLK_EN_IN),
        .wr_in      (wr_lock),
        .key_wr_in  (WDATA_IN[`PDL_KEY_BIT]),
        .mask_wr_in (WDATA_IN[PIN_W-1:0]),
        .key_out    (lock_key_bit),
        .mask_out   (lock_mask),
        .freeze_out (PIN_FREEZE_OUT)
    );

    assign LOCK_KEY_OUT = lock_key_bit;

    // Read mux; atomic registers and holes read zero
    always_comb begin
        next_rdata = `PDL_WORD_ZERO;
        if (RD_IN) begin
            if (hit(ADDR_IN, `PDL_OFS_INPUT)) begin
                next_rdata[PIN_W-1:0] = pin_level;
            end else if (hit(ADDR_IN, `PDL_OFS_LATCH)) begin
                next_rdata[PIN_W-1:0] = out_latch;
            end else if (hit(ADDR_IN, `PDL_OFS_LOCK)) begin
                next_rdata[`PDL_KEY_BIT] = lock_key_bit;
                next_rdata[PIN_W-1:0]    = lock_mask;
            end
        end
    end

    // Read data stands for the enabled cycle after the strobe and holds while the clock enable is low
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            RDATA_OUT <= `PDL_WORD_ZERO;
        end else if (CLK_EN_IN) begin
            RDATA_OUT <= next_rdata;
        end
    end

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_rd(logic [7:0] ofs);
        CLK_EN_IN && RD_IN && hit(ADDR_IN, ofs);
    endsequence

    sequence s_wr(logic [7:0] ofs);
        CLK_EN_IN && WR_IN && hit(ADDR_IN, ofs);
    endsequence

    a_input_read: assert property (
        s_rd(`PDL_OFS_INPUT) |=>
            RDATA_OUT == {16'h0000, $past(pin_level)})
        else $error("input word read mismatch");

    a_latch_write: assert property (
        s_wr(`PDL_OFS_LATCH) |=> out_latch == $past(WDATA_IN[15:0]))
        else $error("latch write not stored");

    a_latch_readback: assert property (
        s_wr(`PDL_OFS_LATCH) ##1 s_rd(`PDL_OFS_LATCH) |=>
            RDATA_OUT == {16'h0000, $past(WDATA_IN[15:0], 2)})
        else $error("latch readback mismatch");

    a_set_bits: assert property (
        s_wr(`PDL_OFS_SETCLR) |=>
            (out_latch & $past(WDATA_IN[15:0])) == $past(WDATA_IN[15:0]))
        else $error("set bit not applied");

    a_clear_bits: assert property (
        s_wr(`PDL_OFS_SETCLR) |=>
            (out_latch & $past(WDATA_IN[31:16] & ~WDATA_IN[15:0])) == 16'h0000)
        else $error("clear bit not applied");

    a_keep_untouched: assert property (
        s_wr(`PDL_OFS_SETCLR) |=>
            ((out_latch ^ $past(out_latch))
             & ~$past(WDATA_IN[31:16] | WDATA_IN[15:0])) == 16'h0000)
        else $error("unaddressed latch bit changed");

    a_setclr_reads_zero: assert property (
        s_rd(`PDL_OFS_SETCLR) or s_rd(`PDL_OFS_CLRONLY) |=>
            RDATA_OUT == 32'h0000_0000)
        else $error("atomic register read not zero");

    a_clear_only: assert property (
        s_wr(`PDL_OFS_CLRONLY) |=>
            out_latch == ($past(out_latch) & ~$past(WDATA_IN[15:0])))
        else $error("clear-only write wrong");

    a_lock_read: assert property (
        s_rd(`PDL_OFS_LOCK) |=>
            RDATA_OUT == {15'h0000, $past(lock_key_bit), $past(lock_mask)})
        else $error("lock register read mismatch");

    a_idle_read_zero: assert property (
        CLK_EN_IN && !RD_IN |=> RDATA_OUT == 32'h0000_0000)
        else $error("read data outside read slot");

    a_frozen_hold: assert property (
        !CLK_EN_IN |=> $stable(out_latch) && $stable(RDATA_OUT))
        else $error("state moved with clock enable low");

    a_key_sequence: assert property (
        s_wr(`PDL_OFS_LOCK) ##0 (WDATA_IN[`PDL_KEY_BIT] && !lock_key_bit)
        ##1 s_wr(`PDL_OFS_LOCK) ##0 (!WDATA_IN[`PDL_KEY_BIT]
            && WDATA_IN[15:0] == $past(WDATA_IN[15:0]))
        ##1 s_wr(`PDL_OFS_LOCK) ##0 (WDATA_IN[`PDL_KEY_BIT]
            && WDATA_IN[15:0] == $past(WDATA_IN[15:0]))
        |=> LOCK_KEY_OUT && PIN_FREEZE_OUT == $past(WDATA_IN[15:0]))
        else $error("good key sequence did not lock");
endmodule
`default_nettype wire

/* tb/pdl_port_tb.sv */
// Self-checking testbench for the port data, set/clear and lock block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk;
    logic        rst;
    logic        clk_en;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [15:0] pins;
    logic [15:0] latch;
    logic [15:0] freeze;
    logic        key;
    int          miscompares = 0;
    int          tests_run = 0;
    logic [31:0] got;

    pdl_port i_pdl_port (
        .MCLK_IN        (mclk),
        .RESET_IN       (rst),
        .CLK_EN_IN      (clk_en),
        .ADDR_IN        (addr),
        .WDATA_IN       (wdata),
        .WR_IN          (wr),
        .RD_IN          (rd),
        .RDATA_OUT      (rdata),
        .PIN_LEVEL_IN   (pins),
        .OUT_LATCH_OUT  (latch),
        .PIN_FREEZE_OUT (freeze),
        .LOCK_KEY_OUT   (key)
    );

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Compare and count; unknowns never match
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write; returns once the write edge has landed
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr    <= 1'b0;
        #1;
    endtask

    // One-cycle read; data is taken in the single cycle it stands
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Latch, lock and set/clear registers and the latch, key and freeze outputs after reset
    task automatic test_reset_values;
        check({16'h0000, latch}, 32'h0000_0000);
        check({15'h0000, key, freeze}, 32'h0000_0000);
        bus_rd(8'h14, got);
        check(got, 32'h0000_0000);
        bus_rd(8'h1C, got);
        check(got, 32'h0000_0000);
        bus_rd(8'h18, got);
        check(got, 32'h0000_0000);
        $display("test_reset_values done");
    endtask

    // Pin levels read back, writes there ignored, upper half zero
    task automatic test_input_word;
        @(posedge mclk);
        pins <= 16'hA5C3;
        repeat (3) @(posedge mclk);
        bus_wr(8'h10, 32'hFFFF_0000);
        bus_rd(8'h10, got);
        check(got, 32'h0000_A5C3);
        $display("test_input_word done");
    endtask

    // Latch write, reserved bits dropped, a disabled cycle loses its strobe
    task automatic test_latch;
        bus_wr(8'h14, 32'hFFFF_1234);
        check({16'h0000, latch}, 32'h0000_1234);
        bus_rd(8'h14, got);
        check(got, 32'h0000_1234);
        @(posedge mclk);
        clk_en <= 1'b0;
        bus_wr(8'h14, 32'h0000_FFFF);
        @(posedge mclk);
        clk_en <= 1'b1;
        @(posedge mclk);
        #1;
        check({16'h0000, latch}, 32'h0000_1234);
        $display("test_latch done");
    endtask

    // Set, clear, set beating clear on bit 8, and the clear-only word
    task automatic test_set_clear;
        bus_wr(8'h18, 32'h1130_0101);
        check({16'h0000, latch}, 32'h0000_0305);
        bus_rd(8'h18, got);
        check(got, 32'h0000_0000);
        bus_wr(8'h28, 32'hFFFF_0004);
        check({16'h0000, latch}, 32'h0000_0301);
        bus_rd(8'h28, got);
        check(got, 32'h0000_0000);
        $display("test_set_clear done");
    endtask

    // A broken key sequence leaves the key off and the mask writable
    task automatic test_lock_abort;
        bus_wr(8'h1C, 32'h0001_000F);
        check({31'h0, key}, 32'h0000_0000);
        bus_wr(8'h1C, 32'h0000_000F);
        bus_wr(8'h1C, 32'h0000_000F);
        bus_wr(8'h1C, 32'h0001_000F);
        check({15'h0000, key, freeze}, 32'h0000_0000);
        bus_rd(8'h1C, got);
        check(got, 32'h0000_000F);
        bus_wr(8'h1C, 32'h0000_000F);
        bus_wr(8'h1C, 32'h0001_0007);
        check({15'h0000, key, freeze}, 32'h0000_0000);
        $display("test_lock_abort done");
    endtask

    // Good sequence with another write inside; then the lock holds
    task automatic test_lock_arm;
        bus_wr(8'h1C, 32'h0001_00FF);
        bus_wr(8'h1C, 32'h0000_00FF);
        bus_wr(8'h14, 32'h0000_0042);
        check({16'h0000, latch}, 32'h0000_0042);
        bus_wr(8'h1C, 32'h0001_00FF);
        check({15'h0000, key, freeze}, 32'h0001_00FF);
        bus_rd(8'h1C, got);
        check(got, 32'h0001_00FF);
        bus_wr(8'h1C, 32'hFFFE_FF00);
        bus_rd(8'h1C, got);
        check(got, 32'h0001_00FF);
        check({16'h0000, freeze}, 32'h0000_00FF);
        $display("test_lock_arm done");
    endtask

    // Only a system reset releases the lock
    task automatic test_reset_release;
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        #1;
        check({15'h0000, key, freeze}, 32'h0000_0000);
        check({16'h0000, latch}, 32'h0000_0000);
        bus_rd(8'h1C, got);
        check(got, 32'h0000_0000);
        $display("test_reset_release done");
    endtask

    // Time-zero values, reset, then the scenarios
    initial begin
        rst    = 1'b1;
        clk_en = 1'b1;
        addr   = 8'h00;
        wdata  = 32'h0000_0000;
        wr     = 1'b0;
        rd     = 1'b0;
        pins   = 16'h0000;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        test_reset_values();
        test_input_word();
        test_latch();
        test_set_clear();
        test_lock_abort();
        test_lock_arm();
        test_reset_release();
        give_verdict();
    end

    // Watchdog: the scenarios take well under a thousand cycles
    initial begin
        #20000;
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
`default_nettype wire
